// [tmr_ext_defines.svh]
// Register offsets, field positions, reset values and timing counts
// for the timer external capture/reset block.
// Assumes a 32-bit APB slave decoding a 9-bit byte address window.
`ifndef TMR_EXT_DEFINES_SVH
`define TMR_EXT_DEFINES_SVH

// Pair select bit: pair a at 0x000, pair b at 0x100
`define PAIR_SEL_BIT       8
// Per-timer register offsets within a pair (first / second timer)
`define OFF_CAPTURE_T0     8'h10
`define OFF_CONTROL_T0     8'h14
`define OFF_FLAG_T0        8'h18
`define OFF_CAPTURE_T1     8'h30
`define OFF_CONTROL_T1     8'h34
`define OFF_FLAG_T1        8'h38
// Shared interrupt registers, pair a only
`define OFF_IRQ_STATUS     8'h40
`define OFF_IRQ_CLEAR      8'h44
`define OFF_IRQ_ENABLE     8'h48

// Control field positions
`define CTL_COUNT_PHASE    0
`define CTL_EDGE_LO        1
`define CTL_EDGE_HI        2
`define CTL_PIN_EN         3
`define CTL_RST_CAP_SEL    4
`define CTL_IRQ_EN         5
`define CTL_CAP_DB_EN      6
`define CTL_CNT_DB_EN      7
`define CTL_WIDTH          8
// Flag register field
`define FLAG_EVENT_BIT     0

// Reset values
`define RST_CAPTURE        24'h00_0000
`define RST_CONTROL        8'h00

// Debounce: stable time in ns, cycles at 100 MHz rounded up
`define CLK_PERIOD_NS      10
`define DEBOUNCE_NS        30
`define DEBOUNCE_CYCLES    ((`DEBOUNCE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// [tmr_ext_pkg.sv]
// Types shared by the timer external capture/reset block.
// Assumes the defines header gives the field layout used here.
package tmr_ext_pkg;

  // Edge selection codes of the capture pin
  typedef enum logic [1:0] {
    EDGE_FALL = 2'h0,
    EDGE_RISE = 2'h1,
    EDGE_BOTH = 2'h2,
    EDGE_RSVD = 2'h3
  } edge_sel_t;

  // External pin control word, bit 7 down to bit 0
  typedef struct packed {
    logic      count_pin_debounce_en;
    logic      capture_pin_debounce_en;
    logic      ext_event_irq_enable;
    logic      reset_or_capture_select;
    logic      ext_pin_enable;
    edge_sel_t ext_edge_select;
    logic      count_phase;
  } ext_pin_control_t;

  // Per-timer pin side inputs
  typedef struct packed {
    logic capture_pin;
    logic count_pin;
    logic timer_tick;
    logic event_count_mode;
  } timer_pins_t;

endpackage : tmr_ext_pkg

// [timer_external_capture_reset.sv]
// Capture/reset logic on the external pins of four 24-bit up-timers,
// with APB registers and a shared level interrupt.
// Assumes pins are asynchronous to pclk; timer_tick is a pclk-domain
// prescaler pulse from the base timer.
// Capture and count pins rest high when idle.
`timescale 1ns/1ps
`include "tmr_ext_defines.svh"

// How it works
// - Selected capture edge latches up-timer count
// - Capture register read-only, bits 31:24 zero
// - Bit 7 enables counting pin debounce
// - Bit 6 enables capture pin debounce
// - Bit 5 enables external event interrupt on ext_irq only
// - Code 00: falling edge sets event flag
// - Bit 4: one resets counter, zero captures
// - Bit 3 enables external pin, else ignored
// - Edge code: fall, rise, both, reserved
// - Bit 0 picks counted edge of count pin
// - Capture and control reset to zero
// - Four timers, two per base, fixed offsets
// - Event flag bit 0, write one clears
// - Event mode counts counting pin edges
module timer_external_capture_reset #(
  parameter int NUM_TIMERS = 4,
  parameter int CNT_W      = 24,
  parameter int DB_CYCLES  = `DEBOUNCE_CYCLES
) (
  // Clock and reset
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  // APB slave
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [8:0]                    paddr,
  input  wire logic [31:0]                   pwdata,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  // Timer pins and base timer controls
  input  tmr_ext_pkg::timer_pins_t [NUM_TIMERS-1:0] pins,
  // Counter values and interrupts
  output logic      [NUM_TIMERS-1:0][CNT_W-1:0] counter_value,
  output logic      [NUM_TIMERS-1:0]         ext_irq,
  output logic                               irq
);
  import tmr_ext_pkg::*;

  localparam int NPIN = 2 * NUM_TIMERS;    // Capture pins then count pins
  localparam int DBW  = $clog2(DB_CYCLES + 1);
  // Stability count at which a debounced level is taken
  localparam logic [DBW-1:0] DB_LAST = DBW'(DB_CYCLES - 1);
  // Level the pins rest at, also the reset value of every pin stage
  localparam logic PIN_IDLE = 1'b1;
  // Word slot of each timer register inside its group of four words
  localparam logic [1:0] SLOT_CAP  = 2'(`OFF_CAPTURE_T0 >> 2);
  localparam logic [1:0] SLOT_CTL  = 2'(`OFF_CONTROL_T0 >> 2);
  localparam logic [1:0] SLOT_FLAG = 2'(`OFF_FLAG_T0 >> 2);

  // Register state, all but the up-counters visible to software
  ext_pin_control_t              ctrl_q   [NUM_TIMERS];  // Control words
  logic [CNT_W-1:0]              cap_q    [NUM_TIMERS];  // Captured counts
  logic [CNT_W-1:0]              cnt_q    [NUM_TIMERS];  // Up-counters
  logic [NUM_TIMERS-1:0]         flag_q;                 // Event flags
  logic [NUM_TIMERS-1:0]         status_q;               // Sticky status
  logic [NUM_TIMERS-1:0]         irq_en_q;               // Status enables
  logic [31:0]                   prdata_q;               // Read data

  // Pin conditioning: three-stage sync, agree filter, debounce
  logic [NPIN-1:0]               pin_raw;     // Raw pin levels
  logic [NPIN-1:0]               db_en;       // Debounce enable per pin
  logic [NPIN-1:0]               s1_q;        // First sync stage
  logic [NPIN-1:0]               s2_q;        // Second sync stage
  logic [NPIN-1:0]               s3_q;        // Third sync stage
  logic [NPIN-1:0]               lvl_q;       // Conditioned level
  logic [NPIN-1:0]               lvl_prev_q;  // Level one clock earlier
  logic [DBW-1:0]                db_cnt_q [NPIN]; // Stability counters
  logic [NPIN-1:0]               rise;        // Rising edge of level
  logic [NPIN-1:0]               fall;        // Falling edge of level

  // Map pins and debounce enables
  // Capture pins take the low indices, count pins those above
  generate
    for (genvar i = 0; i < NUM_TIMERS; i++) begin : g_map
      assign pin_raw[i]            = pins[i].capture_pin;
      assign pin_raw[NUM_TIMERS+i] = pins[i].count_pin;
      assign db_en[i]              = ctrl_q[i].capture_pin_debounce_en;
      assign db_en[NUM_TIMERS+i]   = ctrl_q[i].count_pin_debounce_en;
    end
  endgenerate

  // Synchroniser chain; first stage feeds only the second.
  // Stages reset to the idle level, so settling after reset
  // is not mistaken for an edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= {NPIN{PIN_IDLE}};
      s2_q <= {NPIN{PIN_IDLE}};
      s3_q <= {NPIN{PIN_IDLE}};
    end else begin
      s1_q <= pin_raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Per-pin level filter
  // A change is believed only once stages two and three agree
  generate
    for (genvar p = 0; p < NPIN; p++) begin : g_pin
      logic agree;      // Second and third stages match
      logic differs;    // Synced level differs from conditioned level
      logic stable;     // Difference held long enough
      assign agree   = (s2_q[p] == s3_q[p]);
      assign differs = agree && (s3_q[p] != lvl_q[p]);
      assign stable  = (db_cnt_q[p] >= DB_LAST);

      // Counts clocks a new level has held; restarts on bounce.
      // Stops at the stable count so it can never wrap.
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          db_cnt_q[p] <= '0;
        end else if (!differs || !db_en[p]) begin
          db_cnt_q[p] <= '0;
        end else if (!stable) begin
          db_cnt_q[p] <= db_cnt_q[p] + DBW'(1);
        end
      end

      // Level follows when stages agree, and if debounced, when stable.
      // Without debounce a change passes as soon as the stages agree.
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          lvl_q[p]      <= PIN_IDLE;
          lvl_prev_q[p] <= PIN_IDLE;
        end else begin
          lvl_prev_q[p] <= lvl_q[p];
          if (differs && (!db_en[p] || stable)) begin
            lvl_q[p] <= s3_q[p];
          end
        end
      end

      // One-clock pulses on each change of the conditioned level
      assign rise[p] = lvl_q[p] & ~lvl_prev_q[p];
      assign fall[p] = ~lvl_q[p] & lvl_prev_q[p];
    end
  endgenerate

  // APB decode
  logic                          setup_ph;    // Setup cycle
  logic                          wr_acc;      // Write taken this edge
  logic [7:0]                    off;         // Offset inside a pair
  logic                          pair_b;      // Second base selected
  logic                          in_timer;    // Offset in timer block
  logic                          sub_t1;      // Second timer of a pair
  logic [1:0]                    tsel;        // Timer index
  logic [1:0]                    slot;        // Word slot inside a timer group
  logic                          hit_cap;     // Capture register
  logic                          hit_ctl;     // Control register
  logic                          hit_flag;    // Flag register
  logic                          hit_stat;    // Interrupt status
  logic                          hit_clr;     // Interrupt clear
  logic                          hit_ien;     // Interrupt enable
  logic                          mapped;      // Any register hit

  // Bus phases; state changes only at the access edge of a write
  assign setup_ph = psel & ~penable;
  assign wr_acc   = psel & penable & pwrite;
  assign off      = paddr[7:0];
  assign pair_b   = paddr[`PAIR_SEL_BIT];
  // Timer registers sit at 0x10..0x18 and 0x30..0x38 of each pair
  assign in_timer = (off[7:6] == 2'h0) & off[4] & (off[1:0] == 2'h0);
  assign sub_t1   = off[5];
  // Timer index is the pair bit over the within-pair bit
  assign tsel     = {pair_b, sub_t1};
  assign slot     = off[3:2];
  assign hit_cap  = in_timer & (slot == SLOT_CAP);
  assign hit_ctl  = in_timer & (slot == SLOT_CTL);
  assign hit_flag = in_timer & (slot == SLOT_FLAG);
  // Interrupt registers exist in pair a only
  assign hit_stat = ~pair_b & (off == `OFF_IRQ_STATUS);
  assign hit_clr  = ~pair_b & (off == `OFF_IRQ_CLEAR);
  assign hit_ien  = ~pair_b & (off == `OFF_IRQ_ENABLE);
  // Anything else is refused through pslverr
  assign mapped   = hit_cap | hit_ctl | hit_flag | hit_stat | hit_clr | hit_ien;

  // Zero wait states; unmapped addresses answer with an error
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign prdata  = prdata_q;

  // Read words of each register, reserved bits zero
  logic [31:0]                   rd_cap;      // Capture word
  logic [31:0]                   rd_ctl;      // Control word
  logic [31:0]                   rd_flag;     // Flag word
  logic [31:0]                   rd_stat;     // Status word
  logic [31:0]                   rd_ien;      // Enable word
  logic [31:0]                   rd_mux;      // Selected word
  assign rd_cap  = {8'h00, cap_q[tsel]};
  assign rd_ctl  = {24'h00_0000, ctrl_q[tsel]};
  assign rd_flag = {31'h0, flag_q[tsel]};
  assign rd_stat = {{(32-NUM_TIMERS){1'b0}}, status_q};
  assign rd_ien  = {{(32-NUM_TIMERS){1'b0}}, irq_en_q};
  // Read mux; the write-only clear register reads zero
  assign rd_mux = hit_cap  ? rd_cap  :
                  hit_ctl  ? rd_ctl  :
                  hit_flag ? rd_flag :
                  hit_stat ? rd_stat :
                  hit_ien  ? rd_ien  :
                  32'h0000_0000;

  // Read data is latched in the setup cycle, stable through access
  // Reads have no side effect, so taking the word early is harmless
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup_ph && !pwrite) begin
      prdata_q <= rd_mux;
    end
  end

  // Per-timer event logic
  logic [NUM_TIMERS-1:0]         ext_edge;    // Qualifying capture edge
  logic [NUM_TIMERS-1:0]         ext_reset;   // Counter reset request
  logic [NUM_TIMERS-1:0]         ext_cap;     // Capture request
  logic [NUM_TIMERS-1:0]         cnt_step;    // Counter increment
  logic [NUM_TIMERS-1:0]         wr_ctl;      // Control write strobe
  logic [NUM_TIMERS-1:0]         flag_clr;    // Flag write-one-clear

  generate
    for (genvar i = 0; i < NUM_TIMERS; i++) begin : g_tmr
      logic edge_hit;   // Edge matches selection
      logic cnt_edge;   // Counted edge of the counting pin
      logic sel_me;     // Bus targets this timer

      // Edge selection; reserved code detects nothing
      always_comb begin
        case (ctrl_q[i].ext_edge_select)
          EDGE_FALL: edge_hit = fall[i];
          EDGE_RISE: edge_hit = rise[i];
          EDGE_BOTH: edge_hit = rise[i] | fall[i];
          default:   edge_hit = 1'b0;
        endcase
      end

      // Pin enable gates capture, reset and flag alike
      assign ext_edge[i]  = ctrl_q[i].ext_pin_enable & edge_hit;
      assign ext_reset[i] = ext_edge[i] & ctrl_q[i].reset_or_capture_select;
      assign ext_cap[i]   = ext_edge[i] & ~ctrl_q[i].reset_or_capture_select;

      // Phase picks rising or falling count pin edge
      // Base ticks count unless event mode selects the count pin
      assign cnt_edge    = ctrl_q[i].count_phase ? rise[NUM_TIMERS+i]
                                                 : fall[NUM_TIMERS+i];
      assign cnt_step[i] = pins[i].event_count_mode ? cnt_edge
                                                    : pins[i].timer_tick;

      // Bus strobes aimed at this timer
      assign sel_me      = (tsel == 2'(i));
      assign wr_ctl[i]   = wr_acc & hit_ctl & sel_me;
      assign flag_clr[i] = wr_acc & hit_flag & sel_me & pwdata[`FLAG_EVENT_BIT];

      // Control register, low eight bits writable
      // Upper bits are reserved and read back as zero
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          ctrl_q[i] <= `RST_CONTROL;
        end else if (wr_ctl[i]) begin
          ctrl_q[i] <= pwdata[`CTL_WIDTH-1:0];
        end
      end

      // Up-counter; external reset wins over increment
      // A reset edge and a tick in one clock leave zero
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cnt_q[i] <= '0;
        end else if (ext_reset[i]) begin
          cnt_q[i] <= '0;
        end else if (cnt_step[i]) begin
          cnt_q[i] <= cnt_q[i] + CNT_W'(1);
        end
      end

      // Capture register, loaded only in capture mode
      // Reset mode leaves it alone, keeping the last capture
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cap_q[i] <= `RST_CAPTURE;
        end else if (ext_cap[i]) begin
          cap_q[i] <= cnt_q[i];
        end
      end

      // Event flag: a new edge wins over a clear
      // so an edge during the clearing write is not lost
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          flag_q[i] <= 1'b0;
        end else begin
          flag_q[i] <= (flag_q[i] & ~flag_clr[i]) | ext_edge[i];
        end
      end

      // Per-timer request to the interrupt controller
      // Follows the sticky flag until software clears it
      assign ext_irq[i]       = flag_q[i] & ctrl_q[i].ext_event_irq_enable;
      assign counter_value[i] = cnt_q[i];
    end
  endgenerate

  // Shared interrupt status, clear and enable
  logic [NUM_TIMERS-1:0]         stat_clr;    // Write-one-clear mask

  // Only a write to the clear register yields a mask
  assign stat_clr = (wr_acc & hit_clr) ? pwdata[NUM_TIMERS-1:0] : '0;

  // Sticky status; setting edge beats clear
  // Same set-over-clear priority as the per-timer flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q <= '0;
    end else begin
      status_q <= (status_q & ~stat_clr) | ext_edge;
    end
  end

  // Status enable register
  // Masks only the shared request, never the status bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_en_q <= '0;
    end else if (wr_acc && hit_ien) begin
      irq_en_q <= pwdata[NUM_TIMERS-1:0];
    end
  end

  // Level interrupt while any enabled status bit is set
  // A bit set while disabled raises the request once enabled
  assign irq = |(status_q & irq_en_q);

endmodule : timer_external_capture_reset

// [pin_partner.sv]
// Model of the capture and count pins and of the interrupt controller.
// Assumes the bench calls set_pin from a process that follows pclk edges.
`timescale 1ns/1ps
module pin_partner (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Request from the block
  input  wire logic       irq,
  // Pin levels, idle high
  output logic      [3:0] cap,
  output logic      [3:0] cnt
);
  int   irq_seen; // Request edges taken by the controller
  logic irq_q;    // Last sampled request

  initial begin
    cap      = 4'hf;
    cnt      = 4'hf;
    irq_seen = 0;
  end

  // Controller counts each new level request
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq;
      if (irq && !irq_q) irq_seen <= irq_seen + 1;
    end
  end

  // Pins move just after an edge, never in step with sampling
  task automatic set_pin(input int t, input bit is_cnt, input logic v);
    @(posedge pclk);
    if (is_cnt) cnt[t] <= v;
    else cap[t] <= v;
  endtask : set_pin
endmodule : pin_partner

// [timer_ext_monitor.sv]
// Checker of APB answers, counter behaviour and pin reaction.
// Assumes timer 0 never runs in reset mode and only the capture pin
// of timer 1 clears its counter.
`timescale 1ns/1ps
module timer_ext_monitor
  import tmr_ext_pkg::*;
#(
  parameter int NUM_TIMERS = 4,
  parameter int CNT_W      = 24,
  parameter int DB_CYCLES  = 3
) (
  // Clock and reset
  input wire logic                                   pclk,
  input wire logic                                   presetn,
  // APB
  input wire logic                                   psel,
  input wire logic                                   penable,
  input wire logic                                   pwrite,
  input wire logic [8:0]                             paddr,
  input wire logic [31:0]                            pwdata,
  input wire logic [31:0]                            prdata,
  input wire logic                                   pready,
  input wire logic                                   pslverr,
  // Pins, counters, interrupts
  input wire tmr_ext_pkg::timer_pins_t [NUM_TIMERS-1:0] pins,
  input wire logic [NUM_TIMERS-1:0][CNT_W-1:0]       counter_value,
  input wire logic [NUM_TIMERS-1:0]                  ext_irq,
  input wire logic                                   irq
);
  logic       cap_q;   // Last level of timer 1 capture pin
  logic [7:0] since_q; // Cycles since that pin moved, saturating

  // Age of the last capture pin change
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_q   <= 1'b1;
      since_q <= 8'hff;
    end else begin
      cap_q   <= pins[1].capture_pin;
      since_q <= (pins[1].capture_pin != cap_q) ? 8'h00 : since_q + {7'h0, since_q != 8'hff};
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Access phase of a transfer
  sequence apb_access;
    psel && penable;
  endsequence
  // Read access followed by an idle cycle
  sequence read_then_idle;
    apb_access ##0 !pwrite ##1 !psel;
  endsequence

  pready_high_a: assert property (pready)
    else $error("pready low");
  slverr_phase_a: assert property (pslverr |-> psel && penable)
    else $error("pslverr outside access");
  slverr_data_a: assert property (apb_access ##0 pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read gave data");
  rdata_hold_a: assert property (read_then_idle |-> $stable(prdata))
    else $error("read data moved");
  rst_clear_a: assert property ($rose(presetn) |-> counter_value == '0 && !irq)
    else $error("state not cleared by reset");
  tick_count_a: assert property (
    pins[0].timer_tick && !pins[0].event_count_mode
    |=> counter_value[0] == CNT_W'($past(counter_value[0]) + 1))
    else $error("tick did not count");
  idle_hold_a: assert property (
    !pins[0].timer_tick && !pins[0].event_count_mode
    |=> $stable(counter_value[0]))
    else $error("counter moved without tick");
  ext_reset_lat_a: assert property ($fell(|counter_value[1]) |-> since_q >= 8'd2 && since_q <= 8'd30)
    else $error("counter reset not from pin");
endmodule : timer_ext_monitor

bind timer_external_capture_reset timer_ext_monitor #(.NUM_TIMERS(NUM_TIMERS), .CNT_W(CNT_W),
  .DB_CYCLES(DB_CYCLES)) mon (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready, .pslverr, .pins, .counter_value, .ext_irq, .irq);

// [timer_external_capture_reset_tb.sv]
// Self-checking bench: APB register tests and pin scenarios.
// Assumes pin_partner drives the pins and the monitor is bound.
`timescale 1ns/1ps
module timer_external_capture_reset_tb;
  import tmr_ext_pkg::*;
  localparam int DB = 6; // Longer filter so a short glitch is rejected
  logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, slv;
  logic        [8:0] paddr;
  logic       [31:0] pwdata, prdata, q;
  logic        [3:0] cap, cnt, tick, mode, ext_irq;
  timer_pins_t [3:0] pins;
  logic  [3:0][23:0] counter_value;
  int                err_count, n_compared, exp_cnt;
  logic              hit;

  // Pack the pin bundle of each timer
  for (genvar g = 0; g < 4; g++) begin : g_pin
    assign pins[g] = {cap[g], cnt[g], tick[g], mode[g]};
  end

  timer_external_capture_reset #(.DB_CYCLES(DB)) uut (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .pins, .counter_value,
    .ext_irq, .irq);
  pin_partner partner (.pclk, .presetn, .irq, .cap, .cnt);

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  function automatic logic [8:0] ra(input int t, input logic [7:0] off);
    return {t[1], off | (t[0] ? 8'h20 : 8'h00)};
  endfunction : ra

  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      err_count++;
    end
  endtask : chk

  // One APB transfer; result left in q and slv
  task automatic apb(input logic w, input logic [8:0] a, input logic [31:0] d);
    int n;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      err_count++;
      print_verdict();
    end
    q   = prdata;
    slv = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic rd(input logic [8:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk("register", e, q);
  endtask : rd

  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask : idle

  task automatic tick_n(input int t, input int n);
    repeat (n) begin
      tick[t] <= 1'b1;
      @(posedge pclk);
      tick[t] <= 1'b0;
      @(posedge pclk);
    end
  endtask : tick_n

  // Low pulse of about n cycles on one pin
  task automatic glitch(input int t, input bit c, input int n);
    partner.set_pin(t, c, 1'b0);
    idle(n);
    partner.set_pin(t, c, 1'b1);
    idle(20);
  endtask : glitch

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 9'h000;
    pwdata = 32'h0;
    tick = 4'h0;
    mode = 4'h4;
    err_count = 0;
    n_compared = 0;
    exp_cnt = 0;
    idle(8);
    presetn <= 1'b1;
    @(posedge pclk);
    // Reset values, read-only capture, reserved control bits
    for (int t = 0; t < 4; t++) begin
      rd(ra(t, 8'h10), 32'h0);
      rd(ra(t, 8'h14), 32'h0);
      apb(1'b1, ra(t, 8'h10), 32'hffff_ffff);
      rd(ra(t, 8'h10), 32'h0);
      apb(1'b1, ra(t, 8'h14), 32'hffff_ffff);
      rd(ra(t, 8'h14), 32'hff);
      apb(1'b1, ra(t, 8'h14), 32'h0);
    end
    rd(9'h0fc, 32'h0);
    chk("pslverr", 32'h1, 32'(slv));
    // Every edge code against both pin directions, irq enable on odd codes
    tick_n(0, 5);
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, ra(0, 8'h14), 32'(8 | (c << 1) | ((c & 1) << 5)));
      for (int lv = 0; lv < 2; lv++) begin
        partner.set_pin(0, 1'b0, lv[0]);
        idle(16);
        hit = (c == 2) || (c == lv);
        rd(ra(0, 8'h18), 32'(hit));
        chk("ext_irq", 32'(hit & c[0]), 32'(ext_irq[0]));
        apb(1'b1, ra(0, 8'h18), 32'h1);
      end
    end
    rd(ra(0, 8'h10), 32'h5);
    // Shared status, enable and clear
    rd(9'h040, 32'h1);
    chk("irq", 32'h0, 32'(irq));
    apb(1'b1, 9'h048, 32'h1);
    chk("irq", 32'h1, 32'(irq));
    idle(1); // Let the controller model take the new request
    chk("irq_seen", 32'h1, 32'(partner.irq_seen));
    apb(1'b1, 9'h044, 32'h1);
    rd(9'h040, 32'h0);
    chk("irq", 32'h0, 32'(irq));
    apb(1'b1, 9'h048, 32'h0);
    // Pin disabled, then capture debounce
    apb(1'b1, ra(0, 8'h14), 32'h0);
    glitch(0, 1'b0, 20);
    rd(ra(0, 8'h18), 32'h0);
    apb(1'b1, ra(0, 8'h14), 32'h48);
    glitch(0, 1'b0, 3);
    rd(ra(0, 8'h18), 32'h0);
    glitch(0, 1'b0, 20);
    rd(ra(0, 8'h18), 32'h1);
    // Counter reset mode keeps capture
    tick_n(1, 7);
    chk("count1", 32'h7, 32'(counter_value[1]));
    apb(1'b1, ra(1, 8'h14), 32'h18);
    partner.set_pin(1, 1'b0, 1'b0);
    idle(16);
    chk("count1", 32'h0, 32'(counter_value[1]));
    rd(ra(1, 8'h10), 32'h0);
    // Count pin phase on timer 2 in event mode
    for (int ph = 1; ph >= 0; ph--) begin
      apb(1'b1, ra(2, 8'h14), 32'(ph));
      for (int lv = 0; lv < 2; lv++) begin
        partner.set_pin(2, 1'b1, lv[0]);
        idle(16);
        exp_cnt += (lv == ph);
        chk("count2", 32'(exp_cnt), 32'(counter_value[2]));
      end
    end
    apb(1'b1, ra(2, 8'h14), 32'h81);
    glitch(2, 1'b1, 3);
    chk("count2", 32'(exp_cnt), 32'(counter_value[2]));
    print_verdict();
  end
endmodule : timer_external_capture_reset_tb
